// [test/oam_mem_model.sv]
// memory partner answering word reads after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module oam_mem_model (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        mem_req,
	input  wire logic [15:0] mem_addr,
	input  wire logic [1:0]  lat,
	output logic             mem_ack,
	output logic      [15:0] mem_rdata
);
	logic [1:0] wait_reg;
	always_ff @(posedge core_clk)
	begin
		if (!rstn || !mem_req || mem_ack)
		begin
			wait_reg  <= 2'h0;
			mem_ack   <= 1'b0;
			mem_rdata <= rstn ? ~mem_rdata : 16'h5a5a;
		end
		else if (wait_reg == lat)
		begin
			mem_ack   <= 1'b1;
			mem_rdata <= mem_addr ^ 16'h3c3c;
		end
		else
			wait_reg <= wait_reg + 2'h1;
	end
endmodule : oam_mem_model
`default_nettype wire

// [test/operand_address_mode_unit_bench.sv]
// self-checking bench of the operand addressing unit
`timescale 1ns/1ps
`default_nettype none
module operand_address_mode_unit_bench;
	import oam_pkg::*;
	logic        core_clk = 0, rstn = 0, op_start = 0, op_double = 0, op_byte = 0;
	logic        stk_push = 0, stk_pop = 0, wr_en = 0, mem_req, mem_ack, busy, res_valid;
	logic [15:0] op_instr = 0, wr_data = 0, mem_addr, mem_rdata, rd_data;
	logic [2:0]  wr_num = 0, rd_num = 0;
	logic [1:0]  lat = 0;
	oam_result_s res;
	oam_result_s r [2];
	int          failures = 0, total_checks = 0, reqs = 0;
	oam_unit DUT (.core_clk(core_clk), .rstn(rstn), .op_start(op_start), .op_instr(op_instr),
		.op_double(op_double), .op_byte(op_byte), .stk_push(stk_push), .stk_pop(stk_pop),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.wr_en(wr_en), .wr_num(wr_num), .wr_data(wr_data), .rd_num(rd_num),
		.rd_data(rd_data), .busy(busy), .res_valid(res_valid), .res(res));
	oam_mem_model mem (.core_clk(core_clk), .rstn(rstn), .mem_req(mem_req),
		.mem_addr(mem_addr), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	initial
		forever #50 core_clk = ~core_clk;
	// counted at the falling edge, where mem_req has settled after the state change
	always @(negedge core_clk)
		if (mem_req === 1'b1)
			reqs++;
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			failures++;
		end
	endtask : chk
	task complete_run();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	task setreg(input logic [2:0] n, input logic [15:0] d);
		@(negedge core_clk);
		{wr_en, wr_num, wr_data} = {1'b1, n, d};
		@(negedge core_clk);
		wr_en = 0;
	endtask : setreg
	task getreg(input logic [2:0] n, input logic [15:0] e);
		rd_num = n;
		#1;
		chk("register", e, rd_data);
	endtask : getreg
	// one request, then collect the wanted number of results under a bound
	task run(input logic [2:0] kind, input logic [15:0] ins, input logic dbl, byt,
		input int want);
		int got;
		got = 0;
		@(negedge core_clk);
		{op_start, stk_push, stk_pop} = kind;
		{op_instr, op_double, op_byte} = {ins, dbl, byt};
		@(negedge core_clk);
		{op_start, stk_push, stk_pop} = 3'h0;
		for (int k = 0; k < 60 && got < want; k++)
		begin
			if (res_valid === 1'b1)
			begin
				r[got] = res;
				got++;
			end
			if (got < want)
				@(negedge core_clk);
		end
		if (got < want)
		begin
			failures++;
			complete_run();
		end
	endtask : run
	task res_is(input int i, input logic [5:0] f, input logic [15:0] a, v);
		chk("flags", {10'h0, f}, {10'h0, r[i].is_reg, r[i].is_src, r[i].is_stack, r[i].num});
		chk("address", a, r[i].addr);
		chk("value", v, r[i].value);
	endtask : res_is
	task t_direct();
		int q;
		setreg(3'h1, 16'h1234);
		q = reqs;
		run(3'h4, 16'h0001, 0, 0, 1);
		res_is(0, 6'h21, 16'h0, 16'h1234);
		run(3'h4, 16'h0009, 0, 0, 1);
		res_is(0, 6'h01, 16'h1234, 16'h0);
		chk("memory reads", q[15:0], reqs[15:0]);
		getreg(3'h1, 16'h1234);
	endtask : t_direct
	task t_step();
		logic [2:0]  n;
		logic [15:0] s;
		for (int b = 0; b < 2; b++)
			for (int j = 0; j < 2; j++)
			begin
				n = j ? 3'h6 : 3'h1;
				s = (b == 1 && j == 0) ? 16'h1 : 16'h2;
				setreg(n, 16'h0100);
				run(3'h4, {10'h0, 3'h2, n}, 0, b[0], 1);
				res_is(0, {3'h0, n}, 16'h0100, 16'h0);
				getreg(n, 16'h0100 + s);
				run(3'h4, {10'h0, 3'h4, n}, 0, b[0], 1);
				res_is(0, {3'h0, n}, 16'h0100, 16'h0);
				getreg(n, 16'h0100);
			end
	endtask : t_step
	task t_defer();
		lat = 2'h2;
		setreg(3'h2, 16'h0200);
		run(3'h4, 16'h001a, 0, 1, 1);
		res_is(0, 6'h02, 16'h0200 ^ 16'h3c3c, 16'h0);
		getreg(3'h2, 16'h0202);
		run(3'h4, 16'h002a, 0, 1, 1);
		res_is(0, 6'h02, 16'h0200 ^ 16'h3c3c, 16'h0);
		getreg(3'h2, 16'h0200);
	endtask : t_defer
	task t_index();
		lat = 2'h0;
		setreg(3'h7, 16'h1000);
		setreg(3'h3, 16'h0010);
		run(3'h4, 16'h0033, 0, 0, 1);
		res_is(0, 6'h03, (16'h1000 ^ 16'h3c3c) + 16'h0010, 16'h0);
		getreg(3'h3, 16'h0010);
		run(3'h4, 16'h003b, 0, 0, 1);
		res_is(0, 6'h03, ((16'h1002 ^ 16'h3c3c) + 16'h0010) ^ 16'h3c3c, 16'h0);
		getreg(3'h3, 16'h0010);
		getreg(3'h7, 16'h1004);
	endtask : t_index
	task t_pc();
		setreg(3'h7, 16'h2000);
		run(3'h4, 16'h0017, 0, 1, 1);
		res_is(0, 6'h07, 16'h2000, 16'h0);
		getreg(3'h7, 16'h2002);
		run(3'h4, 16'h001f, 0, 0, 1);
		res_is(0, 6'h07, 16'h2002 ^ 16'h3c3c, 16'h0);
		run(3'h4, 16'h0037, 0, 0, 1);
		res_is(0, 6'h07, (16'h2004 ^ 16'h3c3c) + 16'h2006, 16'h0);
		getreg(3'h7, 16'h2006);
	endtask : t_pc
	task t_double();
		setreg(3'h1, 16'h0300);
		setreg(3'h2, 16'h0055);
		run(3'h4, 16'h0442, 1, 0, 2);
		res_is(0, 6'h11, 16'h0300, 16'h0);
		res_is(1, 6'h22, 16'h0, 16'h0055);
		run(3'h4, 16'h0442, 0, 0, 1);
		res_is(0, 6'h22, 16'h0, 16'h0055);
		getreg(3'h1, 16'h0302);
	endtask : t_double
	task t_stack();
		setreg(3'h6, 16'h0400);
		run(3'h2, 16'h0, 0, 0, 1);
		res_is(0, 6'h0e, 16'h03fe, 16'h0);
		getreg(3'h6, 16'h03fe);
		run(3'h1, 16'h0, 0, 0, 1);
		res_is(0, 6'h0e, 16'h03fe, 16'h0);
		getreg(3'h6, 16'h0400);
	endtask : t_stack
	task t_refuse();
		lat = 2'h2;
		setreg(3'h7, 16'h3000);
		setreg(3'h4, 16'h0040);
		@(negedge core_clk);
		{op_start, op_instr, op_double, op_byte} = {1'b1, 16'h0034, 2'h0};
		@(negedge core_clk);
		// requests held on while busy must be dropped without trace
		{op_instr, stk_push} = {16'h0014, 1'b1};
		@(negedge core_clk);
		{op_start, stk_push} = 2'h0;
		run(3'h0, 16'h0014, 0, 0, 1);
		res_is(0, 6'h04, (16'h3000 ^ 16'h3c3c) + 16'h0040, 16'h0);
		repeat (4) @(negedge core_clk);
		getreg(3'h4, 16'h0040);
		getreg(3'h6, 16'h0400);
		getreg(3'h7, 16'h3002);
	endtask : t_refuse
	initial
	begin
		repeat (6) @(negedge core_clk);
		rstn = 1;
		for (int n = 0; n < 8; n++)
			getreg(n[2:0], 16'h0);
		chk("busy", 16'h0, {15'h0, busy});
		t_direct();
		t_step();
		t_defer();
		t_index();
		t_pc();
		t_double();
		t_stack();
		t_refuse();
		complete_run();
	end
endmodule : operand_address_mode_unit_bench
`default_nettype wire

// [verilog/oam_pkg.sv]
// types of the operand addressing unit
package oam_pkg;

	typedef enum logic [2:0] {
		OAM_M_REG    = 3'h0,
		OAM_M_REGDEF = 3'h1,
		OAM_M_AINC   = 3'h2,
		OAM_M_AINCDF = 3'h3,
		OAM_M_ADEC   = 3'h4,
		OAM_M_ADECDF = 3'h5,
		OAM_M_IDX    = 3'h6,
		OAM_M_IDXDEF = 3'h7
	} oam_mode_e;

	typedef struct packed {
		oam_mode_e   mode;
		logic [2:0]  num;
	} oam_spec_s;

	typedef struct packed {
		logic        is_reg;
		logic        is_src;
		logic        is_stack;
		logic [2:0]  num;
		logic [15:0] addr;
		logic [15:0] value;
	} oam_result_s;

endpackage : oam_pkg

// [verilog/oam_regs.svh]
// constants of the operand addressing unit
`ifndef OAM_REGS_SVH
`define OAM_REGS_SVH
`define OAM_SP_NUM    3'h6
`define OAM_PC_NUM    3'h7
`define OAM_WORD_STEP 16'h0002
`define OAM_BYTE_STEP 16'h0001
`define OAM_REG_RESET 16'h0000
`define OAM_SRC_LSB   6
`define OAM_DST_LSB   0
`define OAM_SPEC_W    6
`endif

// [verilog/oam_step.sv]
// register step size for the auto-stepping modes
`timescale 1ns/1ps
`default_nettype none
module oam_step
	import oam_pkg::*;
(
	input  wire oam_mode_e   mode,
	input  wire logic [2:0]  num,
	input  wire logic        is_byte,
	output logic      [15:0] step
);
`include "oam_regs.svh"

	always_comb
	begin
		step = `OAM_WORD_STEP;
		if ((mode == OAM_M_AINC || mode == OAM_M_ADEC) && is_byte
			&& num != `OAM_SP_NUM && num != `OAM_PC_NUM)
			step = `OAM_BYTE_STEP;
	end

endmodule : oam_step
`default_nettype wire

// [verilog/oam_unit.sv]
// operand addressing unit: mode decode, register stepping, index and pointer fetch
`timescale 1ns/1ps
`default_nettype none
module oam_unit
	import oam_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        op_start,
	input  wire logic [15:0] op_instr,
	input  wire logic        op_double,
	input  wire logic        op_byte,
	input  wire logic        stk_push,
	input  wire logic        stk_pop,
	output logic             mem_req,
	output logic      [15:0] mem_addr,
	input  wire logic        mem_ack,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        wr_en,
	input  wire logic [2:0]  wr_num,
	input  wire logic [15:0] wr_data,
	input  wire logic [2:0]  rd_num,
	output logic      [15:0] rd_data,
	output logic             busy,
	output logic             res_valid,
	output oam_result_s      res
);
`include "oam_regs.svh"

	typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_XFETCH, ST_PTR} oam_state_e;

	oam_state_e  state_reg, state_next;
	oam_spec_s   spec_reg, spec_next;
	oam_spec_s   dst_reg, dst_next;
	logic        is_src_reg, is_src_next;
	logic        byte_reg, byte_next;
	logic [15:0] maddr_reg, maddr_next;
	logic        res_valid_reg, res_valid_next;
	oam_result_s res_reg, res_next;
	logic [15:0] regs_reg [8];
	logic [15:0] regs_next [8];
	logic [15:0] cur_val;
	logic [15:0] pc_w;
	logic [15:0] sp_w;
	logic [15:0] step_w;
	logic [15:0] ea_w;
	logic        fin;

	assign cur_val   = regs_reg[spec_reg.num];
	assign pc_w      = regs_reg[`OAM_PC_NUM];
	assign sp_w      = regs_reg[`OAM_SP_NUM];
	assign ea_w      = mem_rdata + cur_val;
	assign mem_req   = (state_reg == ST_XFETCH) || (state_reg == ST_PTR);
	assign mem_addr  = maddr_reg;
	assign rd_data   = regs_reg[rd_num];
	assign busy      = (state_reg != ST_IDLE);
	assign res_valid = res_valid_reg;
	assign res       = res_reg;

	oam_step u_step (
		.mode    (spec_reg.mode),
		.num     (spec_reg.num),
		.is_byte (byte_reg),
		.step    (step_w)
	);

	always_comb
	begin
		state_next     = state_reg;
		spec_next      = spec_reg;
		dst_next       = dst_reg;
		is_src_next    = is_src_reg;
		byte_next      = byte_reg;
		maddr_next     = maddr_reg;
		res_valid_next = 1'b0;
		res_next       = res_reg;
		regs_next      = regs_reg;
		fin            = 1'b0;
		// external write first; address stepping below overrides the same register
		if (wr_en)
			regs_next[wr_num] = wr_data;
		unique case (state_reg)
			ST_IDLE:
			begin
				if (op_start)
				begin
					dst_next    = oam_spec_s'(op_instr[`OAM_DST_LSB +: `OAM_SPEC_W]);
					spec_next   = op_double ? oam_spec_s'(op_instr[`OAM_SRC_LSB +: `OAM_SPEC_W])
						: oam_spec_s'(op_instr[`OAM_DST_LSB +: `OAM_SPEC_W]);
					is_src_next = op_double;
					byte_next   = op_byte;
					state_next  = ST_DECODE;
				end
				else if (stk_push || stk_pop)
				begin
					res_next          = '0;
					res_next.is_stack = 1'b1;
					res_next.num      = `OAM_SP_NUM;
					res_next.addr     = stk_push ? sp_w - `OAM_WORD_STEP : sp_w;
					regs_next[`OAM_SP_NUM] = stk_push ? sp_w - `OAM_WORD_STEP
						: sp_w + `OAM_WORD_STEP;
					res_valid_next    = 1'b1;
				end
			end
			ST_DECODE:
			begin
				res_next        = '0;
				res_next.is_src = is_src_reg;
				res_next.num    = spec_reg.num;
				unique case (spec_reg.mode)
					OAM_M_REG:
					begin
						res_next.is_reg = 1'b1;
						res_next.value  = cur_val;
						fin             = 1'b1;
					end
					OAM_M_REGDEF:
					begin
						res_next.addr = cur_val;
						fin           = 1'b1;
					end
					OAM_M_AINC:
					begin
						res_next.addr = cur_val;
						regs_next[spec_reg.num] = cur_val + step_w;
						fin           = 1'b1;
					end
					OAM_M_AINCDF:
					begin
						maddr_next = cur_val;
						regs_next[spec_reg.num] = cur_val + `OAM_WORD_STEP;
						state_next = ST_PTR;
					end
					OAM_M_ADEC:
					begin
						res_next.addr = cur_val - step_w;
						regs_next[spec_reg.num] = cur_val - step_w;
						fin           = 1'b1;
					end
					OAM_M_ADECDF:
					begin
						maddr_next = cur_val - `OAM_WORD_STEP;
						regs_next[spec_reg.num] = cur_val - `OAM_WORD_STEP;
						state_next = ST_PTR;
					end
					OAM_M_IDX, OAM_M_IDXDEF:
					begin
						// next instruction word sits at the counter, which moves past it
						maddr_next = pc_w;
						regs_next[`OAM_PC_NUM] = pc_w + `OAM_WORD_STEP;
						state_next = ST_XFETCH;
					end
				endcase
			end
			ST_XFETCH:
			begin
				if (mem_ack)
				begin
					if (spec_reg.mode == OAM_M_IDXDEF)
					begin
						maddr_next = ea_w;
						state_next = ST_PTR;
					end
					else
					begin
						res_next.addr = ea_w;
						fin           = 1'b1;
					end
				end
			end
			ST_PTR:
			begin
				if (mem_ack)
				begin
					res_next.addr = mem_rdata;
					fin           = 1'b1;
				end
			end
		endcase
		if (fin)
		begin
			res_valid_next = 1'b1;
			if (is_src_reg)
			begin
				is_src_next = 1'b0;
				spec_next   = dst_reg;
				state_next  = ST_DECODE;
			end
			else
				state_next = ST_IDLE;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			state_reg     <= ST_IDLE;
			spec_reg      <= '0;
			dst_reg       <= '0;
			is_src_reg    <= 1'b0;
			byte_reg      <= 1'b0;
			maddr_reg     <= '0;
			res_valid_reg <= 1'b0;
			res_reg       <= '0;
			for (int i = 0; i < 8; i++)
				regs_reg[i] <= `OAM_REG_RESET;
		end
		else
		begin
			state_reg     <= state_next;
			spec_reg      <= spec_next;
			dst_reg       <= dst_next;
			is_src_reg    <= is_src_next;
			byte_reg      <= byte_next;
			maddr_reg     <= maddr_next;
			res_valid_reg <= res_valid_next;
			res_reg       <= res_next;
			regs_reg      <= regs_next;
		end
	end

	logic dec_w;
	assign dec_w = (state_reg == ST_DECODE);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	a_reg_no_mem: assert property (dec_w && spec_reg.mode == OAM_M_REG
		|=> res_valid && res.is_reg && res.value == $past(cur_val) && !mem_req)
		else $error("register mode result wrong");
	a_defer_addr: assert property (dec_w && spec_reg.mode == OAM_M_REGDEF
		|=> res_valid && res.addr == $past(cur_val))
		else $error("register deferred address wrong");
	a_autoinc_step: assert property (dec_w && spec_reg.mode == OAM_M_AINC && !wr_en
		|=> res.addr == $past(cur_val)
		&& regs_reg[$past(spec_reg.num)] == $past(cur_val) + $past(step_w))
		else $error("autoincrement wrong");
	a_autodec_addr: assert property (dec_w && spec_reg.mode == OAM_M_ADEC && !wr_en
		|=> res.addr == $past(cur_val) - $past(step_w)
		&& regs_reg[$past(spec_reg.num)] == res.addr)
		else $error("autodecrement wrong");
	a_deferinc_two: assert property (dec_w && spec_reg.mode == OAM_M_AINCDF && !wr_en
		|=> mem_req && mem_addr == $past(cur_val)
		&& regs_reg[$past(spec_reg.num)] == $past(cur_val) + 16'h0002)
		else $error("autoincrement deferred wrong");
	a_deferdec_two: assert property (dec_w && spec_reg.mode == OAM_M_ADECDF
		|=> mem_req && mem_addr == $past(cur_val) - 16'h0002)
		else $error("autodecrement deferred wrong");
	a_index_sum: assert property (state_reg == ST_XFETCH && mem_ack
		&& spec_reg.mode == OAM_M_IDX |=> res_valid && res.addr == $past(ea_w))
		else $error("index address wrong");
	a_idxdef_ptr: assert property (state_reg == ST_XFETCH && mem_ack
		&& spec_reg.mode == OAM_M_IDXDEF |=> state_reg == ST_PTR && mem_addr == $past(ea_w))
		else $error("index deferred pointer wrong");
	a_pc_fetch: assert property (dec_w && spec_reg.mode[2:1] == 2'b11 && !wr_en
		|=> mem_addr == $past(pc_w) && pc_w == $past(pc_w) + 16'h0002)
		else $error("next word fetch wrong");
	a_step_size: assert property (dec_w && byte_reg && spec_reg.num < 3'h6
		&& (spec_reg.mode == OAM_M_AINC || spec_reg.mode == OAM_M_ADEC) |-> step_w == 16'h0001)
		else $error("byte step wrong");
	a_stack_push: assert property (state_reg == ST_IDLE && !op_start && stk_push
		|=> res_valid && res.is_stack && res.addr == $past(sp_w) - 16'h0002)
		else $error("stack push address wrong");
	a_src_then_dst: assert property (res_valid && res.is_src |-> state_reg == ST_DECODE
		&& !is_src_reg)
		else $error("destination not decoded after source");

	c_idxdef_done: cover property (state_reg == ST_PTR && mem_ack && spec_reg.mode == OAM_M_IDXDEF);
	c_double_op: cover property (res_valid && res.is_src ##[1:20] res_valid && !res.is_src);
	c_immediate: cover property (dec_w && spec_reg.mode == OAM_M_AINC && spec_reg.num == 3'h7);
	c_stack_pop: cover property (state_reg == ST_IDLE && !op_start && !stk_push && stk_pop);

endmodule : oam_unit
`default_nettype wire
